// ==== common/uib_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef UIB_REGS_SVH
`define UIB_REGS_SVH

`define UIB_OFS_TXDATA   12'h000
`define UIB_OFS_RXDATA   12'h004
`define UIB_OFS_STATUS   12'h008
`define UIB_OFS_CONFIG   12'h00C
`define UIB_OFS_LATENCY  12'h010
`define UIB_OFS_LINE     12'h014

`define UIB_CFG_FUNC_LSB 0
`define UIB_CFG_FUNC_MSB 1
`define UIB_CFG_VSP_BIT  2
`define UIB_CFG_ADDR_LSB 8
`define UIB_CFG_ADDR_MSB 14

`define UIB_ST_TXCNT_LSB 0
`define UIB_ST_RXCNT_LSB 16
`define UIB_ST_FWD_BIT   28
`define UIB_ST_SUSP_BIT  29
`define UIB_ST_CHG_BIT   30
`define UIB_ST_ENUM_BIT  31

`define UIB_FUNC_OFF     2'h0
`define UIB_FUNC_CHG     2'h1
`define UIB_FUNC_CHG_N   2'h2

`define UIB_FUNC_RST     2'h0
`define UIB_VSP_RST      1'b0
`define UIB_ADDR_RST     7'h22
`define UIB_LAT_RST      8'h10
`define UIB_LINE_RST     32'h0000_0000

`define UIB_FIFO_DEPTH   512
`define UIB_PTR_W        9
`define UIB_CNT_W        10

`define UIB_CLK_NS       40
`define UIB_MS_NS        1000000
`define UIB_MS_CYCLES    ((`UIB_MS_NS + `UIB_CLK_NS - 1) / `UIB_CLK_NS)

`endif

// ==== common/uib_pkg.sv ====
// Types shared by the bridge modules
package uib_pkg;
  typedef logic [7:0] uib_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_OUT,
    ST_RX_BYTE,
    ST_TX_BYTE,
    ST_MACK
  } uib_i2c_state_e;
endpackage : uib_pkg

// ==== common/uib_fifo_if.sv ====
// Push and pop handshake of one byte buffer
`include "uib_regs.svh"

interface uib_fifo_if;
  import uib_pkg::*;
  logic                  push_valid;
  logic                  push_ready;
  uib_byte_t             push_data;
  logic                  pop_valid;
  logic                  pop_ready;
  uib_byte_t             pop_data;
  logic [`UIB_CNT_W-1:0] count;

  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data, count);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data, count);
endinterface : uib_fifo_if

// ==== rtl/uib_byte_fifo.sv ====
// First-in first-out byte buffer, 512 entries
`include "uib_regs.svh"

module uib_byte_fifo
  import uib_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  uib_fifo_if.fifo  port_if
);
  uib_byte_t             mem [0:`UIB_FIFO_DEPTH-1];
  logic [`UIB_PTR_W-1:0] wr_ptr_reg;
  logic [`UIB_PTR_W-1:0] rd_ptr_reg;
  logic [`UIB_CNT_W-1:0] count_reg;
  logic                  do_push;
  logic                  do_pop;

  assign port_if.push_ready = (count_reg != `UIB_CNT_W'(`UIB_FIFO_DEPTH));
  assign port_if.pop_valid  = (count_reg != '0);
  assign port_if.pop_data   = mem[rd_ptr_reg];
  assign port_if.count      = count_reg;
  assign do_push = port_if.push_valid & port_if.push_ready;
  assign do_pop  = port_if.pop_ready & port_if.pop_valid;

  // Storage has no reset; only pointers and count carry state
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= port_if.push_data;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + `UIB_PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + `UIB_PTR_W'(1);
      end
      if (do_push & ~do_pop) begin
        count_reg <= count_reg + `UIB_CNT_W'(1);
      end else if (do_pop & ~do_push) begin
        count_reg <= count_reg - `UIB_CNT_W'(1);
      end
    end
  end
endmodule : uib_byte_fifo

// ==== rtl/uib_bridge.sv ====
// Host to two-wire slave byte bridge with charger-detect pin and APB regs
//
// Behaviour
// - Charger pin asserts when charging port detected.
// - Active-low charger pin offered as alternative function.
// - Pin function comes from nonvolatile configuration settings; here the APB CONFIG register, reset to off.
// - Charging port suspends device; charger only when suspended.
// - Enumerated, not suspended: charger output stays inactive.
// - Host bytes buffered, returned on master reads.
// - Only payload bytes reach host; bus framing hidden.
// - Master bytes forwarded when full or timer expires.
// - Serial clock is never driven; slave only.
// - Baud and handshake settings have no effect.
// - Report serial port option at every enumeration.
// - Serial port option factory default is disabled.
// - Read address refused when transmit buffer empty.
// - Write data byte refused when receive buffer full.
// - Bytes shifted most significant bit first.
//
// Added by the designer: the register offsets and the APB register port.
`include "uib_regs.svh"

module uib_bridge
  import uib_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `UIB_MS_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        usb_suspend_i,
  input  wire logic        usb_enumerated_i,
  input  wire logic        dcp_detect_i,
  output logic             configurable_io_pin_o,
  output logic             virtual_serial_port_option_o
);
  uib_fifo_if tx_if ();
  uib_fifo_if rx_if ();

  uib_byte_fifo u_tx_fifo (.clock_i(clock_i), .rst_i(rst_i), .port_if(tx_if));
  uib_byte_fifo u_rx_fifo (.clock_i(clock_i), .rst_i(rst_i), .port_if(rx_if));

  // Synchronisers: stage one feeds only stage two
  logic       scl_s1_reg;
  logic       scl_s2_reg;
  logic       scl_prev_reg;
  logic       sda_s1_reg;
  logic       sda_s2_reg;
  logic       sda_prev_reg;
  logic [2:0] usb_s1_reg;
  logic [2:0] usb_s2_reg;
  logic       enum_prev_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s1_reg    <= 1'b1;
      scl_s2_reg    <= 1'b1;
      scl_prev_reg  <= 1'b1;
      sda_s1_reg    <= 1'b1;
      sda_s2_reg    <= 1'b1;
      sda_prev_reg  <= 1'b1;
      usb_s1_reg    <= 3'h0;
      usb_s2_reg    <= 3'h0;
      enum_prev_reg <= 1'b0;
    end else begin
      scl_s1_reg    <= scl_i;
      scl_s2_reg    <= scl_s1_reg;
      scl_prev_reg  <= scl_s2_reg;
      sda_s1_reg    <= sda_i;
      sda_s2_reg    <= sda_s1_reg;
      sda_prev_reg  <= sda_s2_reg;
      usb_s1_reg    <= {dcp_detect_i, usb_enumerated_i, usb_suspend_i};
      usb_s2_reg    <= usb_s1_reg;
      enum_prev_reg <= usb_s2_reg[1];
    end
  end

  wire scl_w    = scl_s2_reg;
  wire sda_w    = sda_s2_reg;
  wire scl_rise = scl_w & ~scl_prev_reg;
  wire scl_fall = ~scl_w & scl_prev_reg;
  wire bus_start = scl_w & scl_prev_reg & ~sda_w & sda_prev_reg;
  wire bus_stop  = scl_w & scl_prev_reg & sda_w & ~sda_prev_reg;

  // Registers
  logic [1:0]  func_reg;
  logic        vsp_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  lat_reg;
  logic [31:0] line_reg;
  logic [31:0] prdata_reg;
  logic        fwd_reg;
  logic        fwd_next;
  logic        pin_reg;
  logic        vsp_out_reg;

  // APB decode
  wire setup_rd = psel_i & ~penable_i & ~pwrite_i;
  wire access   = psel_i & penable_i;
  wire wr_en    = access & pwrite_i;
  wire rd_en    = access & ~pwrite_i;
  wire sel_tx   = (paddr_i == `UIB_OFS_TXDATA);
  wire sel_rx   = (paddr_i == `UIB_OFS_RXDATA);
  wire sel_st   = (paddr_i == `UIB_OFS_STATUS);
  wire sel_cfg  = (paddr_i == `UIB_OFS_CONFIG);
  wire sel_lat  = (paddr_i == `UIB_OFS_LATENCY);
  wire sel_line = (paddr_i == `UIB_OFS_LINE);
  wire sel_any  = sel_tx | sel_rx | sel_st | sel_cfg | sel_lat | sel_line;

  // Device power state
  wire suspended  = usb_s2_reg[0] | usb_s2_reg[2];
  wire enumerated = usb_s2_reg[1];
  wire chg_active = usb_s2_reg[2] & suspended & ~enumerated;

  wire [31:0] status_w;
  assign status_w = {enumerated, chg_active, suspended, fwd_reg,
                     2'h0, rx_if.count, 6'h0, tx_if.count};

  wire [31:0] cfg_w = {17'h0, addr_reg, 5'h0, vsp_reg, func_reg};

  logic [31:0] rd_mux;
  always_comb begin
    if (sel_rx) begin
      rd_mux = fwd_reg ? {24'h0, rx_if.pop_data} : 32'h0;
    end else if (sel_st) begin
      rd_mux = status_w;
    end else if (sel_cfg) begin
      rd_mux = cfg_w;
    end else if (sel_lat) begin
      rd_mux = {24'h0, lat_reg};
    end else if (sel_line) begin
      rd_mux = line_reg;
    end else begin
      rd_mux = 32'h0;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~sel_any;
  assign prdata_o  = prdata_reg;

  // Host side of both buffers carries payload bytes only
  assign tx_if.push_valid = wr_en & sel_tx;
  assign tx_if.push_data  = pwdata_i[7:0];
  wire   rx_pop           = rd_en & sel_rx & fwd_reg & rx_if.pop_valid;
  assign rx_if.pop_ready  = rx_pop;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      func_reg   <= `UIB_FUNC_RST;
      vsp_reg    <= `UIB_VSP_RST;
      addr_reg   <= `UIB_ADDR_RST;
      lat_reg    <= `UIB_LAT_RST;
      line_reg   <= `UIB_LINE_RST;
      prdata_reg <= 32'h0;
    end else begin
      if (setup_rd) begin
        prdata_reg <= rd_mux;
      end
      if (wr_en & sel_cfg) begin
        func_reg <= pwdata_i[`UIB_CFG_FUNC_MSB:`UIB_CFG_FUNC_LSB];
        vsp_reg  <= pwdata_i[`UIB_CFG_VSP_BIT];
        addr_reg <= pwdata_i[`UIB_CFG_ADDR_MSB:`UIB_CFG_ADDR_LSB];
      end
      if (wr_en & sel_lat) begin
        lat_reg <= pwdata_i[7:0];
      end
      // Stored for the host driver's benefit; only the APB read-back uses it
      if (wr_en & sel_line) begin
        line_reg <= pwdata_i;
      end
    end
  end

  // Charger pin and enumeration report
  logic pin_next;
  always_comb begin
    if (func_reg == `UIB_FUNC_CHG) begin
      pin_next = chg_active;
    end else if (func_reg == `UIB_FUNC_CHG_N) begin
      pin_next = ~chg_active;
    end else begin
      pin_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg     <= 1'b0;
      vsp_out_reg <= `UIB_VSP_RST;
    end else begin
      pin_reg <= pin_next;
      if (enumerated & ~enum_prev_reg) begin
        vsp_out_reg <= vsp_reg;
      end
    end
  end

  assign configurable_io_pin_o        = pin_reg;
  assign virtual_serial_port_option_o = vsp_out_reg;

  // Latency timer: counts milliseconds while unsent bytes wait
  logic [15:0] ms_cnt_reg;
  logic [7:0]  lat_cnt_reg;
  wire         timer_run = rx_if.pop_valid & ~fwd_reg;
  wire [7:0]   lat_lim   = (lat_reg == 8'h00) ? 8'h01 : lat_reg;
  wire         expire    = timer_run & (lat_cnt_reg >= lat_lim);
  wire         rx_full   = ~rx_if.push_ready;
  wire         fwd_set   = rx_full | expire;
  wire         fwd_clr   = rx_pop & (rx_if.count == `UIB_CNT_W'(1));

  // Set wins so a forward coinciding with the last drain is kept
  assign fwd_next = fwd_set | (fwd_reg & ~fwd_clr);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_reg  <= 16'h0000;
      lat_cnt_reg <= 8'h00;
      fwd_reg     <= 1'b0;
    end else begin
      fwd_reg <= fwd_next;
      if (~timer_run) begin
        ms_cnt_reg  <= 16'h0000;
        lat_cnt_reg <= 8'h00;
      end else if (ms_cnt_reg == 16'(MS_CYCLES - 1)) begin
        ms_cnt_reg  <= 16'h0000;
        lat_cnt_reg <= lat_cnt_reg + 8'h01;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
    end
  end

  // Two-wire slave engine; SCL is input only
  uib_i2c_state_e state_reg;
  logic [7:0]     shift_reg;
  logic [3:0]     cnt_reg;
  logic           is_read_reg;
  logic           oe_n_reg;

  wire addr_hit  = (shift_reg[7:1] == addr_reg);
  wire want_read = shift_reg[0];
  wire addr_ok   = addr_hit & (want_read ? tx_if.pop_valid
                                         : rx_if.push_ready);
  wire load_tx   = (state_reg == ST_ACK_OUT) & scl_fall & is_read_reg;
  wire [7:0] tx_byte = tx_if.pop_data;
  wire store_rx  = (state_reg == ST_RX_BYTE) & scl_fall
                 & (cnt_reg == 4'h8) & rx_if.push_ready;

  assign tx_if.pop_ready  = load_tx;
  assign rx_if.push_valid = store_rx;
  assign rx_if.push_data  = shift_reg;
  assign sda_o            = 1'b0;
  assign sda_oe_n_o       = oe_n_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= 8'h00;
      cnt_reg     <= 4'h0;
      is_read_reg <= 1'b0;
      oe_n_reg    <= 1'b1;
    end else if (bus_start) begin
      state_reg <= ST_ADDR;
      cnt_reg   <= 4'h0;
      oe_n_reg  <= 1'b1;
    end else if (bus_stop) begin
      state_reg <= ST_IDLE;
      oe_n_reg  <= 1'b1;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_w};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall & (cnt_reg == 4'h8)) begin
            if (addr_ok) begin
              oe_n_reg    <= 1'b0;
              is_read_reg <= want_read;
              state_reg   <= ST_ACK_OUT;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            cnt_reg <= is_read_reg ? 4'h1 : 4'h0;
            if (is_read_reg) begin
              // Empty buffer after an acked byte returns all ones
              shift_reg <= tx_if.pop_valid ? tx_byte : 8'hFF;
              oe_n_reg  <= tx_if.pop_valid ? tx_byte[7] : 1'b1;
              state_reg <= ST_TX_BYTE;
            end else begin
              oe_n_reg  <= 1'b1;
              state_reg <= ST_RX_BYTE;
            end
          end
        end
        ST_RX_BYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_w};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall & (cnt_reg == 4'h8)) begin
            if (rx_if.push_ready) begin
              oe_n_reg  <= 1'b0;
              state_reg <= ST_ACK_OUT;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_TX_BYTE: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              oe_n_reg  <= 1'b1;
              state_reg <= ST_MACK;
            end else begin
              oe_n_reg  <= shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b1};
              cnt_reg   <= cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            state_reg <= sda_w ? ST_IDLE : ST_ACK_OUT;
          end
        end
        default: begin
          oe_n_reg <= 1'b1;
        end
      endcase
    end
  end
endmodule : uib_bridge

// ==== verif/uib_bridge_asserts.sv ====
// Port-level checks of the bridge, attached by bind
`include "uib_regs.svh"

module uib_bridge_asserts (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        scl_i,
  input wire logic        sda_oe_n_o,
  input wire logic        usb_suspend_i,
  input wire logic        usb_enumerated_i,
  input wire logic        dcp_detect_i,
  input wire logic        configurable_io_pin_o,
  input wire logic        virtual_serial_port_option_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] func_q;
  logic       vsp_q;
  wire logic  pin = configurable_io_pin_o;
  wire logic  opt = virtual_serial_port_option_o;
  wire logic  enm = usb_enumerated_i;
  wire logic  chg = dcp_detect_i & usb_suspend_i & ~enm;
  wire logic  cfg_wr = psel_i & penable_i & pwrite_i
                       & (paddr_i == `UIB_OFS_CONFIG);

  // Pin setting mirrored from bus writes, since it is not visible at ports
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      func_q <= `UIB_FUNC_RST;
      vsp_q  <= `UIB_VSP_RST;
    end else if (cfg_wr) begin
      func_q <= pwdata_i[1:0];
      vsp_q  <= pwdata_i[2];
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Six cycles leave room for the input synchronisers
  sequence s_chg(logic [1:0] f);
    (func_q == f && chg) [*6];
  endsequence

  chg_on_a: assert property (
    s_chg(`UIB_FUNC_CHG) |-> pin)
    else $error("Charger pin not raised");
  chg_low_a: assert property (
    s_chg(`UIB_FUNC_CHG_N) |-> !pin)
    else $error("Active-low charger pin not lowered");
  chg_enum_a: assert property (
    (func_q == `UIB_FUNC_CHG && enm) [*6] |-> !pin)
    else $error("Charger pin active while enumerated");
  chg_idle_a: assert property (
    (func_q == `UIB_FUNC_CHG_N && enm) [*6] |-> pin)
    else $error("Active-low charger pin not idle high");
  func_off_a: assert property (
    (func_q == `UIB_FUNC_OFF) [*4] |-> !pin)
    else $error("Pin driven with function off");
  opt_a: assert property (
    $rose(enm) ##1 enm [*6] |-> opt == vsp_q)
    else $error("Option not reported on enumeration");
  opt_chg_a: assert property (
    $changed(opt) |-> $past(enm, 2) && opt == vsp_q)
    else $error("Option changed outside enumeration");
  oe_edge_a: assert property (
    $changed(sda_oe_n_o) |-> !$past(scl_i))
    else $error("Data line changed while clock high");
endmodule : uib_bridge_asserts

// ==== verif/uib_i2c_master.sv ====
// Two-wire bus master model driving the bridge's serial pins
module uib_i2c_master (
  input  wire logic sda_oe_n_i,
  input  wire logic dut_sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b1;
  initial scl_o = 1'b1;
  // Pulled-up line: low while either side pulls it low
  assign sda_o = drv & (sda_oe_n_i | dut_sda_i);

  // Data moves well inside the low phase, sampled mid high phase
  task automatic slot(input logic v, output logic s);
    #40 drv = v;
    #120 scl_o = 1'b1;
    #80 s = sda_o;
    #80 scl_o = 1'b0;
  endtask : slot

  // Start and repeated start; the clock stands high between frames
  task automatic start();
    #40 drv = 1'b1;
    #120 scl_o = 1'b1;
    #80 drv = 1'b0;
    #80 scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #40 drv = 1'b0;
    #120 scl_o = 1'b1;
    #80 drv = 1'b1;
    #80;
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(last, s);
  endtask : recv
endmodule : uib_i2c_master

// ==== verif/test_uib_bridge.sv ====
// Self-checking bench for the host to two-wire slave bridge
`include "uib_regs.svh"

module test_uib_bridge;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned MS = 200;
  // Row: pin function, charger port, suspended, enumerated, expected pin
  localparam logic [5:0] ROWS [7] = '{6'h1D, 6'h14, 6'h1A, 6'h2C,
                                      6'h23, 6'h2F, 6'h0C};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready, perr, e, ack, scl, sda, sda_d, oe_n, pin, opt;
  logic        susp = 1'b0;
  logic        enm = 1'b0;
  logic        dedicated_charging_port = 1'b0;
  logic [7:0]  b;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  uib_bridge #(.MS_CYCLES(MS)) i_uib_bridge (
    .clock_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_n_o(oe_n),
    .usb_suspend_i(susp), .usb_enumerated_i(enm),
    .dcp_detect_i(dedicated_charging_port), .configurable_io_pin_o(pin),
    .virtual_serial_port_option_o(opt));
  uib_i2c_master mst (.sda_oe_n_i(oe_n), .dut_sda_i(sda_d),
    .scl_o(scl), .sda_o(sda));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Bus traffic starts off the clock edge so pin changes never race it
  task automatic frame();
    @(posedge clk);
    #5;
    mst.start();
  endtask : frame

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(opt, 1'b0);
    apb(1'b0, `UIB_OFS_CONFIG, 32'h0);
    chk(r, 32'h0000_2200);
    apb(1'b1, `UIB_OFS_LINE, 32'h0001_C200);
    apb(1'b0, `UIB_OFS_LINE, 32'h0);
    chk(r, 32'h0001_C200);
    apb(1'b0, 12'h020, 32'h0);
    chk(e, 1'b1);
    foreach (ROWS[k]) begin
      apb(1'b1, `UIB_OFS_CONFIG, {17'h0, 7'h22, 6'h0, ROWS[k][5:4]});
      dedicated_charging_port  <= ROWS[k][3];
      susp <= ROWS[k][2];
      enm  <= ROWS[k][1];
      repeat (8) @(posedge clk);
      chk(pin, ROWS[k][0]);
      // A charging port alone must suspend the device
      apb(1'b0, `UIB_OFS_STATUS, 32'h0);
      chk(r[31:29], {ROWS[k][1], ROWS[k][3] & ~ROWS[k][1],
                     ROWS[k][2] | ROWS[k][3]});
    end
    dedicated_charging_port <= 1'b0;
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, `UIB_OFS_CONFIG, {17'h0, 7'h22, 5'h0, v[0], 2'h0});
      enm <= 1'b0;
      repeat (8) @(posedge clk);
      enm <= 1'b1;
      repeat (8) @(posedge clk);
      chk(opt, v[0]);
    end
    apb(1'b1, `UIB_OFS_TXDATA, 32'h0000_00A5);
    apb(1'b1, `UIB_OFS_TXDATA, 32'h0000_003C);
    apb(1'b0, `UIB_OFS_STATUS, 32'h0);
    chk(r[9:0], 10'h002);
    frame();
    mst.send(8'h45, ack);
    chk(ack, 1'b1);
    mst.recv(1'b0, b);
    chk(b, 8'hA5);
    mst.recv(1'b1, b);
    chk(b, 8'h3C);
    mst.start();
    mst.send(8'h45, ack);
    chk(ack, 1'b0);
    mst.stop();
    apb(1'b1, `UIB_OFS_LATENCY, 32'h0000_0001);
    frame();
    mst.send(8'h44, ack);
    mst.send(8'h81, ack);
    mst.send(8'h42, ack);
    chk(ack, 1'b1);
    mst.stop();
    apb(1'b0, `UIB_OFS_STATUS, 32'h0);
    chk(r[28], 1'b0);
    repeat (MS) @(posedge clk);
    apb(1'b0, `UIB_OFS_STATUS, 32'h0);
    chk(r[28], 1'b1);
    apb(1'b0, `UIB_OFS_RXDATA, 32'h0);
    chk(r, 32'h0000_0081);
    apb(1'b0, `UIB_OFS_RXDATA, 32'h0);
    chk(r, 32'h0000_0042);
    // Long latency so only a full buffer can trigger forwarding
    apb(1'b1, `UIB_OFS_LATENCY, 32'h0000_00FF);
    frame();
    mst.send(8'h44, ack);
    for (int i = 0; i < 512; i++) begin
      mst.send(i[7:0], ack);
      chk(ack, 1'b1);
    end
    mst.send(8'hEE, ack);
    chk(ack, 1'b0);
    mst.stop();
    apb(1'b0, `UIB_OFS_STATUS, 32'h0);
    chk(r[28], 1'b1);
    chk(r[25:16], 10'h200);
    frame();
    mst.send(8'h44, ack);
    chk(ack, 1'b0);
    mst.stop();
    for (int i = 0; i < 512; i++) begin
      apb(1'b0, `UIB_OFS_RXDATA, 32'h0);
      chk(r, {24'h0, i[7:0]});
    end
    apb(1'b0, `UIB_OFS_STATUS, 32'h0);
    chk(r[28], 1'b0);
    give_verdict();
  end
endmodule : test_uib_bridge

bind uib_bridge uib_bridge_asserts u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .usb_suspend_i(usb_suspend_i), .usb_enumerated_i(usb_enumerated_i),
  .dcp_detect_i(dcp_detect_i),
  .configurable_io_pin_o(configurable_io_pin_o),
  .virtual_serial_port_option_o(virtual_serial_port_option_o));
